/* File: common/alubit_consts.svh */
// Purpose: Constants for the arithmetic, logic and I/O bit unit
// Assumes: 8-bit data, 5-bit bit-accessible I/O address
// Notes: Flag positions follow the core status register layout
`ifndef ALUBIT_CONSTS_SVH
`define ALUBIT_CONSTS_SVH
`define ALUBIT_FLAG_C 0
`define ALUBIT_FLAG_Z 1
`define ALUBIT_FLAG_N 2
`define ALUBIT_FLAG_V 3
`define ALUBIT_FLAG_S 4
`define ALUBIT_FLAG_H 5
`define ALUBIT_IO_MAX 6'h1f
`define ALUBIT_WORD_CYCLES 2'h2
`define ALUBIT_BYTE_ZERO 8'h00
`define ALUBIT_WORD_ZERO 16'h0000
`endif

/* File: common/alubit_pkg.sv */
// Purpose: Types for the arithmetic, logic and I/O bit unit
// Assumes: Used with alubit_consts.svh
// Notes: Op codes are internal to the core
package alubit_pkg;
  typedef enum logic [3:0] {
    ALUBIT_OP_NONE,
    ALUBIT_OP_ADD,
    ALUBIT_OP_ADC,
    ALUBIT_OP_SUB,
    ALUBIT_OP_SUBC,
    ALUBIT_OP_SUBK,
    ALUBIT_OP_SBCK,
    ALUBIT_OP_WADD,
    ALUBIT_OP_WSUB,
    ALUBIT_OP_AND,
    ALUBIT_OP_ANDK,
    ALUBIT_OP_OR,
    ALUBIT_OP_IOSET,
    ALUBIT_OP_IOCLR,
    ALUBIT_OP_SKIPSET,
    ALUBIT_OP_SKIPCLR
  } alubit_op_t;

  typedef struct packed {
    alubit_op_t op;
    logic [7:0] rd;
    logic [7:0] rd_hi;
    logic [7:0] rr;
    logic [7:0] k;
    logic [5:0] io_addr;
    logic [2:0] bit_sel;
    logic [7:0] io_rdata;
  } alubit_req_t;

  typedef struct packed {
    logic [7:0] mask;
    logic [5:0] addr;
  } alubit_io_wr_t;

  typedef enum logic {
    ALUBIT_ST_IDLE,
    ALUBIT_ST_WORD2
  } alubit_state_t;
endpackage

/* File: src/alubit_unit.sv */
// Purpose: Arithmetic, logic and I/O bit operations of an 8-bit core
// Assumes: Decoder issues one request per i_valid, honours o_busy
// Notes: Word ops take two clocks, all others one
`timescale 1ns/1ps
`default_nettype none
`include "alubit_consts.svh"

module alubit_unit import alubit_pkg::*; (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_valid,
  input wire alubit_req_t i_req,
  input wire logic [7:0] i_sreg,
  output logic o_busy,
  output logic o_wr,
  output logic [7:0] o_wdata,
  output logic o_wr_hi,
  output logic [7:0] o_wdata_hi,
  output logic o_flag_wr,
  output logic [7:0] o_sreg,
  output logic o_io_wr,
  output alubit_io_wr_t o_io,
  output logic o_skip,
  output logic o_io_reject
);
  alubit_state_t state_q, state_d;
  alubit_req_t req_q;
  logic busy_q, wr_q, wr_hi_q, flag_wr_q, io_wr_q, skip_q, rej_q;
  logic [7:0] wdata_q, wdata_hi_q, sreg_q;
  alubit_io_wr_t io_q;

  wire logic take = i_valid && state_q == ALUBIT_ST_IDLE;
  wire alubit_op_t op = i_req.op;
  wire logic cin = i_sreg[`ALUBIT_FLAG_C];
  wire logic is_sub = op == ALUBIT_OP_SUB || op == ALUBIT_OP_SUBC ||
    op == ALUBIT_OP_SUBK || op == ALUBIT_OP_SBCK;
  wire logic is_add = op == ALUBIT_OP_ADD || op == ALUBIT_OP_ADC;
  wire logic use_c = op == ALUBIT_OP_ADC || op == ALUBIT_OP_SUBC ||
    op == ALUBIT_OP_SBCK;
  wire logic is_logic = op == ALUBIT_OP_AND || op == ALUBIT_OP_ANDK ||
    op == ALUBIT_OP_OR;
  wire logic is_word = op == ALUBIT_OP_WADD || op == ALUBIT_OP_WSUB;
  wire logic is_iobit = op == ALUBIT_OP_IOSET || op == ALUBIT_OP_IOCLR;
  wire logic is_skip = op == ALUBIT_OP_SKIPSET || op == ALUBIT_OP_SKIPCLR;
  wire logic io_ok = i_req.io_addr <= `ALUBIT_IO_MAX;

  // Byte arithmetic: constant forms take k as the operand
  wire logic [7:0] opb = (op == ALUBIT_OP_SUBK || op == ALUBIT_OP_SBCK ||
    op == ALUBIT_OP_ANDK) ? i_req.k : i_req.rr;
  wire logic c_in = use_c & cin;
  wire logic [8:0] sum = {1'b0, i_req.rd} + {1'b0, opb} + {8'h00, c_in};
  wire logic [8:0] dif = {1'b0, i_req.rd} - {1'b0, opb} - {8'h00, c_in};
  wire logic [7:0] ar = is_sub ? dif[7:0] : sum[7:0];
  wire logic [7:0] lr = op == ALUBIT_OP_OR ? (i_req.rd | opb)
    : (i_req.rd & opb);
  wire logic [7:0] res = is_logic ? lr : ar;
  wire logic ar_c = is_sub ? dif[8] : sum[8];
  wire logic ar_h = is_sub
    ? (~i_req.rd[3] & opb[3]) | (opb[3] & res[3]) | (res[3] & ~i_req.rd[3])
    : (i_req.rd[3] & opb[3]) | (opb[3] & ~res[3]) | (~res[3] & i_req.rd[3]);
  wire logic ar_v = is_sub
    ? (i_req.rd[7] & ~opb[7] & ~res[7]) | (~i_req.rd[7] & opb[7] & res[7])
    : (i_req.rd[7] & opb[7] & ~res[7]) | (~i_req.rd[7] & ~opb[7] & res[7]);

  // Word arithmetic on the latched pair, second clock
  wire logic [15:0] pair = {req_q.rd_hi, req_q.rd};
  wire logic [16:0] wsum = {1'b0, pair} + {9'h000, req_q.k};
  wire logic [16:0] wdif = {1'b0, pair} - {9'h000, req_q.k};
  wire logic w_sub = req_q.op == ALUBIT_OP_WSUB;
  wire logic [15:0] wres = w_sub ? wdif[15:0] : wsum[15:0];
  wire logic w_c = w_sub ? wdif[16] : wsum[16];
  wire logic w_v = w_sub ? (pair[15] & ~wres[15]) : (~pair[15] & wres[15]);

  // Byte flag image
  logic [7:0] bsreg;
  always_comb begin
    bsreg = i_sreg;
    bsreg[`ALUBIT_FLAG_Z] = res == `ALUBIT_BYTE_ZERO;
    bsreg[`ALUBIT_FLAG_N] = res[7];
    bsreg[`ALUBIT_FLAG_V] = is_logic ? 1'b0 : ar_v;
    if (!is_logic) begin
      bsreg[`ALUBIT_FLAG_C] = ar_c;
      bsreg[`ALUBIT_FLAG_H] = ar_h;
    end
  end

  // Word flag image; sreg may not change between clocks as core stalls
  logic [7:0] wsreg;
  always_comb begin
    wsreg = i_sreg;
    wsreg[`ALUBIT_FLAG_Z] = wres == `ALUBIT_WORD_ZERO;
    wsreg[`ALUBIT_FLAG_N] = wres[15];
    wsreg[`ALUBIT_FLAG_V] = w_v;
    wsreg[`ALUBIT_FLAG_C] = w_c;
    wsreg[`ALUBIT_FLAG_S] = wres[15] ^ w_v;
  end

  // One-hot mask for IOSET so write-one-to-clear neighbours see zero; IOCLR sends its inverse
  wire logic [7:0] bit_mask = 8'h01 << i_req.bit_sel;
  wire logic sel_bit = i_req.io_rdata[i_req.bit_sel];
  wire logic skip_d = is_skip && io_ok &&
    (op == ALUBIT_OP_SKIPSET ? sel_bit : ~sel_bit);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ALUBIT_ST_IDLE: if (take && is_word) state_d = ALUBIT_ST_WORD2;
      ALUBIT_ST_WORD2: state_d = ALUBIT_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= ALUBIT_ST_IDLE;
      req_q <= '0;
    end else begin
      state_q <= state_d;
      if (take) req_q <= i_req;
    end
  end

  wire logic in_word2 = state_q == ALUBIT_ST_WORD2;
  wire logic byte_op = take && (is_add || is_sub || is_logic);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      busy_q <= 1'b0;
      wr_q <= 1'b0;
      wr_hi_q <= 1'b0;
      flag_wr_q <= 1'b0;
      io_wr_q <= 1'b0;
      skip_q <= 1'b0;
      rej_q <= 1'b0;
      wdata_q <= `ALUBIT_BYTE_ZERO;
      wdata_hi_q <= `ALUBIT_BYTE_ZERO;
      sreg_q <= `ALUBIT_BYTE_ZERO;
      io_q <= '0;
    end else begin
      busy_q <= take && is_word;
      wr_q <= byte_op || in_word2;
      wr_hi_q <= in_word2;
      flag_wr_q <= byte_op || in_word2;
      wdata_q <= in_word2 ? wres[7:0] : res;
      wdata_hi_q <= wres[15:8];
      sreg_q <= in_word2 ? wsreg : bsreg;
      io_wr_q <= take && is_iobit && io_ok;
      rej_q <= take && (is_iobit || is_skip) && !io_ok;
      io_q.addr <= i_req.io_addr;
      io_q.mask <= op == ALUBIT_OP_IOSET ? bit_mask : ~bit_mask;
      skip_q <= take && skip_d;
    end
  end

  assign o_busy = busy_q;
  assign o_wr = wr_q;
  assign o_wdata = wdata_q;
  assign o_wr_hi = wr_hi_q;
  assign o_wdata_hi = wdata_hi_q;
  assign o_flag_wr = flag_wr_q;
  assign o_sreg = sreg_q;
  assign o_io_wr = io_wr_q;
  assign o_io = io_q;
  assign o_skip = skip_q;
  assign o_io_reject = rej_q;

  property p_add_one;
    @(posedge i_clk) disable iff (i_reset)
    (i_valid && !busy_q && !in_word2 && op == ALUBIT_OP_ADD) |=>
      o_wr && o_wdata == $past(i_req.rd + i_req.rr);
  endproperty
  a_add_one: assert property (p_add_one) else $error("add wrong");

  property p_word_two;
    @(posedge i_clk) disable iff (i_reset)
    (take && is_word) |=> o_busy && !o_wr ##1 o_wr && o_wr_hi;
  endproperty
  a_word_two: assert property (p_word_two) else $error("word timing");

  property p_sub_carry;
    @(posedge i_clk) disable iff (i_reset)
    (take && op == ALUBIT_OP_SUBC) |=>
      o_wdata == $past(i_req.rd - i_req.rr -
      {7'h00, i_sreg[`ALUBIT_FLAG_C]});
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("sub carry");

  property p_subk;
    @(posedge i_clk) disable iff (i_reset)
    (take && op == ALUBIT_OP_SUBK) |=>
      o_wdata == $past(i_req.rd - i_req.k) && o_flag_wr;
  endproperty
  a_subk: assert property (p_subk) else $error("subk wrong");

  property p_word_sub;
    @(posedge i_clk) disable iff (i_reset)
    (take && op == ALUBIT_OP_WSUB) |=> ##1
      {o_wdata_hi, o_wdata} ==
      $past({i_req.rd_hi, i_req.rd} - {8'h00, i_req.k}, 2);
  endproperty
  a_word_sub: assert property (p_word_sub) else $error("word sub");

  property p_logic_v;
    @(posedge i_clk) disable iff (i_reset)
    (take && is_logic) |=> !o_sreg[`ALUBIT_FLAG_V] &&
      o_sreg[`ALUBIT_FLAG_C] == $past(i_sreg[`ALUBIT_FLAG_C]);
  endproperty
  a_logic_v: assert property (p_logic_v) else $error("logic flags");

  property p_io_range;
    @(posedge i_clk) disable iff (i_reset)
    o_io_wr |-> o_io.addr <= `ALUBIT_IO_MAX;
  endproperty
  a_io_range: assert property (p_io_range) else $error("io range");

  property p_one_bit;
    @(posedge i_clk) disable iff (i_reset)
    o_io_wr |-> ($past(op) == ALUBIT_OP_IOSET ? $onehot(o_io.mask)
      : $onehot(~o_io.mask));
  endproperty
  a_one_bit: assert property (p_one_bit) else $error("mask bits");

  property p_zero;
    @(posedge i_clk) disable iff (i_reset)
    o_flag_wr |-> o_sreg[`ALUBIT_FLAG_Z] == (o_wdata == `ALUBIT_BYTE_ZERO &&
      (!o_wr_hi || o_wdata_hi == `ALUBIT_BYTE_ZERO));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag");

  c_word: cover property (@(posedge i_clk) take && is_word ##2 o_wr_hi);
  c_skip: cover property (@(posedge i_clk) o_skip);
  c_io: cover property (@(posedge i_clk) o_io_wr);
  c_rej: cover property (@(posedge i_clk) o_io_reject);
endmodule // alubit_unit
`default_nettype wire

/* File: test/alu_arith_logic_io_bitops_tb.sv */
// Purpose: Self-checking bench for the arithmetic and I/O bit unit
// Assumes: Flag bits C0 Z1 N2 V3 S4 H5
// Notes: Expected flags tracked beside the core model
`timescale 1ns/1ps
`default_nettype none
module alu_arith_logic_io_bitops_tb import alubit_pkg::*;;
  logic i_clk, i_reset, i_valid;
  alubit_req_t i_req;
  logic [7:0] i_sreg, o_wdata, o_wdata_hi, o_sreg, sreg_e;
  logic o_busy, o_wr, o_wr_hi, o_flag_wr, o_io_wr, o_skip, o_io_reject;
  alubit_io_wr_t o_io;
  int failures, check_count;
  alubit_unit alubit_unit_inst (.i_clk, .i_reset, .i_valid, .i_req,
    .i_sreg, .o_busy, .o_wr, .o_wdata, .o_wr_hi, .o_wdata_hi, .o_flag_wr,
    .o_sreg, .o_io_wr, .o_io, .o_skip, .o_io_reject);
  alubit_core_model alubit_core_model_inst (.i_clk, .i_reset,
    .i_flag_wr(o_flag_wr), .i_new(o_sreg), .o_sreg(i_sreg));
  initial begin
    i_clk = 0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic report_and_stop;
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] f(alubit_op_t op, logic [7:0] a,
      logic [7:0] b, logic [7:0] s);
    logic [8:0] r;
    logic [4:0] h;
    logic sb, c, v;
    logic [7:0] n;
    sb = op inside {ALUBIT_OP_SUB, ALUBIT_OP_SUBC, ALUBIT_OP_SUBK,
      ALUBIT_OP_SBCK};
    c = s[0] & (op inside {ALUBIT_OP_ADC, ALUBIT_OP_SUBC, ALUBIT_OP_SBCK});
    r = sb ? {1'b0, a} - {1'b0, b} - c : {1'b0, a} + b + c;
    h = sb ? {1'b0, a[3:0]} - b[3:0] - c : {1'b0, a[3:0]} + b[3:0] + c;
    v = (a[7] ^ r[7]) & (sb ? a[7] ^ b[7] : ~(a[7] ^ b[7]));
    n = s;
    if (op inside {ALUBIT_OP_AND, ALUBIT_OP_ANDK, ALUBIT_OP_OR}) begin
      r = {1'b0, (op == ALUBIT_OP_OR) ? a | b : a & b};
      v = 1'b0;
    end else begin
      n[0] = r[8];
      n[5] = h[4];
    end
    n[1] = r[7:0] == 8'h00;
    n[2] = r[7];
    n[3] = v;
    return {r[7:0], n};
  endfunction
  task automatic idle;
    i_valid = 0;
    @(posedge i_clk);
    #1;
  endtask
  task automatic op1(alubit_op_t op, logic [7:0] a, logic [7:0] b);
    logic [15:0] e;
    alubit_req_t q;
    e = f(op, a, b, sreg_e);
    q = '0;
    q.op = op;
    q.rd = a;
    q.rr = b;
    q.k = b;
    i_req = q;
    i_valid = 1;
    @(posedge i_clk);
    #1;
    chk({o_wr, o_flag_wr, o_busy, o_io_wr, o_wr_hi, o_skip, o_io_reject},
      7'h60);
    chk({o_wdata, o_sreg}, e);
    sreg_e = e[7:0];
  endtask
  // Valid stays up in the second cycle, which must be ignored
  task automatic wop(alubit_op_t op, logic [15:0] w, logic [7:0] k);
    logic [16:0] r;
    logic [7:0] s;
    alubit_req_t q;
    r = (op == ALUBIT_OP_WADD) ? {1'b0, w} + k : {1'b0, w} - k;
    s = sreg_e;
    s[0] = r[16];
    s[1] = r[15:0] == 16'h0000;
    s[2] = r[15];
    s[3] = (op == ALUBIT_OP_WADD) ? ~w[15] & r[15] : w[15] & ~r[15];
    s[4] = s[2] ^ s[3];
    q = '0;
    q.op = op;
    q.rd = w[7:0];
    q.rd_hi = w[15:8];
    q.k = k;
    i_req = q;
    i_valid = 1;
    @(posedge i_clk);
    #1;
    chk({o_busy, o_wr, o_flag_wr}, 3'h4);
    @(posedge i_clk);
    #1;
    chk({o_busy, o_wr, o_wr_hi, o_flag_wr}, 4'h7);
    chk({o_wdata_hi, o_wdata}, r[15:0]);
    chk(o_sreg, s);
    sreg_e = s;
    idle();
    chk({o_busy, o_wr, o_flag_wr}, 3'h0);
  endtask
  task automatic bop(alubit_op_t op, logic [5:0] a, logic [2:0] b,
      logic [7:0] d, logic [2:0] ex, logic [7:0] m);
    alubit_req_t q;
    q = '0;
    q.op = op;
    q.io_addr = a;
    q.bit_sel = b;
    q.io_rdata = d;
    i_req = q;
    i_valid = 1;
    @(posedge i_clk);
    #1;
    chk({o_io_wr, o_skip, o_io_reject, o_wr, o_flag_wr}, {ex, 2'b00});
    if (ex[2]) chk({o_io.addr, o_io.mask}, {a, m});
  endtask
  initial begin
    repeat (500) @(posedge i_clk);
    failures++;
    report_and_stop();
  end
  initial begin
    i_reset = 1;
    i_valid = 0;
    i_req = '0;
    sreg_e = 8'h00;
    failures = 0;
    check_count = 0;
    repeat (10) @(posedge i_clk);
    #1;
    i_reset = 0;
    chk({o_busy, o_wr, o_wr_hi, o_flag_wr, o_io_wr, o_skip}, 6'h00);
    op1(ALUBIT_OP_ADD, 8'hff, 8'h01);
    op1(ALUBIT_OP_ADC, 8'h7f, 8'h00);
    op1(ALUBIT_OP_SUB, 8'h10, 8'h01);
    op1(ALUBIT_OP_SUBK, 8'h05, 8'h05);
    op1(ALUBIT_OP_SUB, 8'h00, 8'h01);
    op1(ALUBIT_OP_SBCK, 8'h30, 8'h0f);
    op1(ALUBIT_OP_SUBK, 8'h00, 8'h01);
    op1(ALUBIT_OP_SUBC, 8'h80, 8'h00);
    op1(ALUBIT_OP_AND, 8'hf0, 8'h3c);
    op1(ALUBIT_OP_ANDK, 8'h0f, 8'hf0);
    op1(ALUBIT_OP_OR, 8'h80, 8'h01);
    idle();
    wop(ALUBIT_OP_WADD, 16'hffff, 8'h01);
    wop(ALUBIT_OP_WADD, 16'h7fff, 8'h01);
    wop(ALUBIT_OP_WSUB, 16'h0000, 8'h01);
    wop(ALUBIT_OP_WSUB, 16'h8000, 8'h3f);
    bop(ALUBIT_OP_IOSET, 6'h0e, 3'h6, 8'h00, 3'h4, 8'h40);
    bop(ALUBIT_OP_IOCLR, 6'h1f, 3'h0, 8'h00, 3'h4, 8'hfe);
    bop(ALUBIT_OP_IOSET, 6'h20, 3'h1, 8'h00, 3'h1, 8'h00);
    bop(ALUBIT_OP_IOCLR, 6'h3f, 3'h2, 8'h00, 3'h1, 8'h00);
    bop(ALUBIT_OP_SKIPSET, 6'h16, 3'h3, 8'h08, 3'h2, 8'h00);
    bop(ALUBIT_OP_SKIPCLR, 6'h16, 3'h3, 8'h08, 3'h0, 8'h00);
    bop(ALUBIT_OP_SKIPCLR, 6'h00, 3'h7, 8'h7f, 3'h2, 8'h00);
    bop(ALUBIT_OP_SKIPSET, 6'h20, 3'h0, 8'hff, 3'h1, 8'h00);
    idle();
    report_and_stop();
  end
endmodule // alu_arith_logic_io_bitops_tb
`default_nettype wire

/* File: test/alubit_core_model.sv */
// Purpose: Core status register beside the unit
// Assumes: Unit loads flags with a one-cycle pulse
// Notes: Bypass, back-to-back ops need fresh flags
`timescale 1ns/1ps
`default_nettype none
module alubit_core_model (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_flag_wr,
  input wire logic [7:0] i_new,
  output logic [7:0] o_sreg
);
  logic [7:0] sreg_q;
  always_ff @(posedge i_clk) begin
    if (i_reset) sreg_q <= 8'h00;
    else if (i_flag_wr) sreg_q <= i_new;
  end
  // Bypass so a back-to-back take sees the fresh carry
  assign o_sreg = i_flag_wr ? i_new : sreg_q;
endmodule // alubit_core_model
`default_nettype wire
